/* File: design/sgm_safety_gate_monitor.sv */
// Dual-channel safety gate monitor state machine
`default_nettype none
// Notes on behaviour
// - Ready only with feedback and start closed
// - Both channels in window: outputs on, active
// - Gate opens: safety open, aux close, output LEDs out
// - Input LED follows its channel input
// - Output LED lit while on and its channel's contacts read closed
// - Power LED lit while supply good and no earth fault
// - Closed at power-up: wait open then close
// - Automatic mode: active when gate closes
// - Manual mode: gate and start, any order
// - Detect earth, short and cross faults
// - Earth fault drops outputs; 1 min off
// - Welded contact blocks later reactivation
// - One channel or late: outputs stay off
// - Check contacts open again after each cycle
module sgm_safety_gate_monitor #(
   parameter int unsigned SIMUL_CYCLES = sgm_pkg::SIMUL_CYCLES,
   parameter longint unsigned EARTH_OFF_CYCLES = sgm_pkg::EARTH_OFF_CYCLES,
   parameter int unsigned CHECK_CYCLES = sgm_pkg::CHECK_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Supply and mode
   input wire logic supply_ok,
   input wire logic manual_mode,
   // Field inputs, high means closed
   input wire logic gate_switch_a,
   input wire logic gate_switch_b,
   input wire logic start_circuit_input,
   input wire logic feedback_loop_input,
   // Fault sense, high means fault present
   input wire logic earth_fault_sense,
   input wire logic short_sense,
   // Contact readback, high means closed
   input wire logic [sgm_pkg::N_SAFE-1:0] safe_readback,
   // Contacts
   output logic [sgm_pkg::N_SAFE-1:0] safety_out,
   output logic [sgm_pkg::N_AUX-1:0] aux_out,
   // Indicators
   output logic power_indicator,
   output logic input_a_indicator,
   output logic input_b_indicator,
   output logic output_a_indicator,
   output logic output_b_indicator,
   // Status
   output logic ready,
   output logic active,
   output logic earth_fault,
   output logic wiring_fault,
   output logic weld_fault
);
   localparam int unsigned HALF = sgm_pkg::N_SAFE / 2;
   localparam int unsigned N_PINS = 8;

   // Two-stage synchronisers for all field pins
   // Only the second stage feeds logic, so no metastable value reaches a decision
   logic [N_PINS-1:0] sync1;
   logic [N_PINS-1:0] sync2;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= '0;
         sync2 <= '0;
      end else if (clk_en) begin
         sync1 <= {supply_ok, manual_mode, gate_switch_a, gate_switch_b,
                   start_circuit_input, feedback_loop_input, earth_fault_sense,
                   short_sense};
         sync2 <= sync1;
      end
   end

   logic s_supply, s_manual, s_ga, s_gb, s_start, s_fb, s_earth, s_short;
   assign {s_supply, s_manual, s_ga, s_gb, s_start, s_fb, s_earth, s_short} = sync2;

   // Full readback per channel, through its own two-stage synchroniser
   logic [sgm_pkg::N_SAFE-1:0] rb1;
   logic [sgm_pkg::N_SAFE-1:0] rb2;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rb1 <= '0;
         rb2 <= '0;
      end else if (clk_en) begin
         rb1 <= safe_readback;
         rb2 <= rb1;
      end
   end

   function automatic logic all_set(input logic [HALF-1:0] v);
      all_set = &v;
   endfunction
   function automatic logic any_set(input logic [HALF-1:0] v);
      any_set = |v;
   endfunction

   logic rb_a_all, rb_b_all, rb_any;
   assign rb_a_all = all_set(rb2[HALF-1:0]);
   assign rb_b_all = all_set(rb2[sgm_pkg::N_SAFE-1:HALF]);
   assign rb_any = any_set(rb2[HALF-1:0]) | any_set(rb2[sgm_pkg::N_SAFE-1:HALF]);

   logic gate_closed, gate_open, ready_now;
   assign gate_closed = s_ga & s_gb;
   assign gate_open = ~s_ga & ~s_gb;
   assign ready_now = s_fb & s_start;

   sgm_pkg::sgm_state_e state;
   logic [31:0] simul_cnt;
   logic [31:0] check_cnt;
   logic [63:0] off_cnt;
   logic armed;
   logic cross_seen;

   // Wiring fault: short or cross-short, latched until gate fully opens with supply good
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wiring_fault <= 1'b0;
      end else if (clk_en) begin
         if (s_short || cross_seen) begin
            wiring_fault <= 1'b1;
         end else if (gate_open && s_supply) begin
            wiring_fault <= 1'b0;
         end
      end
   end

   // Cross-short: short sensed while one channel is closed and the other open in active state
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cross_seen <= 1'b0;
      end else if (clk_en) begin
         cross_seen <= (state == sgm_pkg::SGM_ACTIVE) && (s_ga ^ s_gb) && s_short;
      end
   end

   // Earth fault latch, cleared only after supply off for the set time
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         earth_fault <= 1'b0;
         off_cnt <= '0;
      end else if (clk_en) begin
         if (s_earth) begin
            earth_fault <= 1'b1;
            off_cnt <= '0;
         end else if (earth_fault) begin
            if (!s_supply) begin
               if (off_cnt >= EARTH_OFF_CYCLES - 64'd1) begin
                  earth_fault <= 1'b0;
                  off_cnt <= '0;
               end else begin
                  off_cnt <= off_cnt + 64'd1;
               end
            end else begin
               off_cnt <= '0;
            end
         end
      end
   end

   // Check timer, restarted on every command change
   logic cmd_on;
   logic cmd_prev;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         check_cnt <= '0;
         cmd_prev <= 1'b0;
      end else if (clk_en) begin
         cmd_prev <= cmd_on;
         if (cmd_on != cmd_prev) begin
            check_cnt <= CHECK_CYCLES;
         end else if (check_cnt != 32'h0) begin
            check_cnt <= check_cnt - 32'h1;
         end
      end
   end

   // Weld latch: readback still closed once the timer has run out
   // The timer covers relay travel and the readback synchroniser delay
   logic check_due;
   assign check_due = (cmd_on == cmd_prev) && (check_cnt <= 32'h1);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         weld_fault <= 1'b0;
      end else if (clk_en) begin
         if (check_due && !cmd_on && rb_any) begin
            weld_fault <= 1'b1;
         end
      end
   end

   // Main sequence
   // Low supply counts as a fault, which also keeps reset in the restart lock
   logic fault_any;
   assign fault_any = earth_fault | wiring_fault | weld_fault | s_earth | ~s_supply;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= sgm_pkg::SGM_LOCKED;
         simul_cnt <= '0;
         armed <= 1'b0;
      end else if (clk_en) begin
         case (state)
            sgm_pkg::SGM_LOCKED: begin
               // Restart lock until the gate is seen open
               if (gate_open && !fault_any) begin
                  state <= sgm_pkg::SGM_IDLE;
               end
            end
            sgm_pkg::SGM_IDLE: begin
               // First channel starts the window, both at once arm directly
               simul_cnt <= '0;
               armed <= 1'b0;
               if (fault_any) begin
                  state <= sgm_pkg::SGM_FAULT;
               end else if ((s_ga || s_gb) && !gate_closed) begin
                  state <= sgm_pkg::SGM_WAIT;
               end else if (gate_closed) begin
                  armed <= 1'b1;
                  state <= sgm_pkg::SGM_WAIT;
               end
            end
            sgm_pkg::SGM_WAIT: begin
               if (fault_any) begin
                  state <= sgm_pkg::SGM_FAULT;
               end else if (gate_open) begin
                  state <= sgm_pkg::SGM_IDLE;
               end else if (!armed) begin
                  if (gate_closed) begin
                     armed <= 1'b1;
                  end else if (simul_cnt >= SIMUL_CYCLES - 32'd1) begin
                     state <= sgm_pkg::SGM_LOCKED;
                  end else begin
                     simul_cnt <= simul_cnt + 32'd1;
                  end
               end else if (!gate_closed) begin
                  state <= sgm_pkg::SGM_LOCKED;
               end else if (s_fb && (!s_manual || s_start)) begin
                  state <= sgm_pkg::SGM_ACTIVE;
               end
            end
            sgm_pkg::SGM_ACTIVE: begin
               // Either channel opening drops both output channels
               if (fault_any || !gate_closed) begin
                  state <= sgm_pkg::SGM_LOCKED;
               end
            end
            sgm_pkg::SGM_FAULT: begin
               if (!fault_any) begin
                  state <= sgm_pkg::SGM_LOCKED;
               end
            end
            default: state <= sgm_pkg::SGM_LOCKED;
         endcase
      end
   end
   assign cmd_on = (state == sgm_pkg::SGM_ACTIVE);

   // Contact drive, safety and aux always opposite
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         safety_out <= '0;
         aux_out <= '1;
      end else if (clk_en) begin
         safety_out <= {sgm_pkg::N_SAFE{cmd_on}};
         aux_out <= {sgm_pkg::N_AUX{~cmd_on}};
      end
   end

   // Indicators
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         power_indicator <= 1'b0;
         input_a_indicator <= 1'b0;
         input_b_indicator <= 1'b0;
         output_a_indicator <= 1'b0;
         output_b_indicator <= 1'b0;
      end else if (clk_en) begin
         power_indicator <= s_supply & ~s_earth & ~earth_fault;
         input_a_indicator <= s_ga;
         input_b_indicator <= s_gb;
         // Lit from readback, so a contact that never closed stays dark
         output_a_indicator <= cmd_on & rb_a_all;
         output_b_indicator <= cmd_on & rb_b_all;
      end
   end

   // Status
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ready <= 1'b0;
         active <= 1'b0;
      end else if (clk_en) begin
         ready <= ready_now & ~fault_any;
         active <= cmd_on;
      end
   end
endmodule
`default_nettype wire

/* File: design/sgm_pkg.sv */
// Constants and types for the safety gate monitor
`default_nettype none
package sgm_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   // Simultaneity window default, in clock cycles
   localparam int unsigned SIMUL_CYCLES = 32'h0000_0400;
   // Supply-off time that clears an earth fault latch
   localparam int unsigned EARTH_OFF_S = 60;
   localparam longint unsigned EARTH_OFF_CYCLES = longint'(EARTH_OFF_S) * longint'(CLK_HZ);
   // Feedback-before-gate time kept by the surroundings
   localparam int unsigned FEEDBACK_LEAD_MS = 500;
   localparam int unsigned FEEDBACK_LEAD_CYCLES = FEEDBACK_LEAD_MS * (CLK_HZ / 1000);
   // Contact check timeout after a command change
   localparam int unsigned CHECK_CYCLES = 32'h0000_0100;
   localparam int unsigned N_SAFE = 6;
   localparam int unsigned N_AUX = 4;
   typedef enum logic [2:0] {
      SGM_LOCKED,
      SGM_IDLE,
      SGM_WAIT,
      SGM_ACTIVE,
      SGM_FAULT
   } sgm_state_e;
endpackage
`default_nettype wire

/* File: sim/sgm_monitor.sv */
// Port checker for the safety gate monitor
`default_nettype none
module sgm_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Field inputs
   input wire logic supply_ok,
   input wire logic manual_mode,
   input wire logic gate_switch_a,
   input wire logic gate_switch_b,
   input wire logic start_circuit_input,
   input wire logic feedback_loop_input,
   // Contacts and status
   input wire logic [sgm_pkg::N_SAFE-1:0] safety_out,
   input wire logic [sgm_pkg::N_AUX-1:0] aux_out,
   input wire logic power_indicator,
   input wire logic input_a_indicator,
   input wire logic input_b_indicator,
   input wire logic output_a_indicator,
   input wire logic output_b_indicator,
   input wire logic ready,
   input wire logic active,
   input wire logic earth_fault,
   input wire logic weld_fault
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n || !clk_en);
   chk_aux_compl: assert property ((safety_out == 6'h00) == (aux_out == 4'hf))
      else $error("aux not complement");
   chk_active_out: assert property (active |-> safety_out == 6'h3f && aux_out == 4'h0)
      else $error("active without contacts");
   chk_in_led: assert property (gate_switch_a[*5] |-> input_a_indicator)
      else $error("input led dark");
   chk_in_led_b: assert property (gate_switch_b[*5] |-> input_b_indicator)
      else $error("input b led dark");
   chk_in_dark: assert property ((!gate_switch_a && !gate_switch_b)[*5] |-> !input_a_indicator && !input_b_indicator)
      else $error("input led lit with gate open");
   chk_out_led: assert property (!active[*2] |-> !output_a_indicator && !output_b_indicator)
      else $error("output led lit while off");
   chk_power_led: assert property (!supply_ok[*5] |-> !power_indicator)
      else $error("power led lit without supply");
   chk_ready_cond: assert property ((!feedback_loop_input || !start_circuit_input)[*5] |-> !ready)
      else $error("ready with open loop");
   chk_rise_gates: assert property ($rose(active) |-> gate_switch_a && gate_switch_b)
      else $error("active with gate open");
   chk_manual_start: assert property ($rose(active) && manual_mode |-> start_circuit_input)
      else $error("manual active without start");
   chk_gate_drop: assert property (active && !gate_switch_a |-> ##[1:6] !active)
      else $error("active after gate open");
   chk_earth_off: assert property (earth_fault[*2] |-> !active && !power_indicator)
      else $error("earth fault not dropping");
   chk_weld_block: assert property (weld_fault |-> !$rose(active))
      else $error("reactivated with weld");
   cover property ($rose(active) && manual_mode);
   cover property ($rose(earth_fault));
   cover property ($rose(weld_fault));
endmodule
bind sgm_safety_gate_monitor sgm_monitor sgm_monitor_i (.*);
`default_nettype wire

/* File: sim/sgm_contact_model.sv */
// Readback model of the external safety contacts
`default_nettype none
module sgm_contact_model (
   input wire logic clk,
   input wire logic weld,
   input wire logic [sgm_pkg::N_SAFE-1:0] safety_out,
   output logic [sgm_pkg::N_SAFE-1:0] safe_readback
);
   timeunit 1ns;
   timeprecision 1ps;
   // Contacts follow a cycle late; a weld holds them closed
   always @(posedge clk) begin
      safe_readback <= weld ? 6'h3f : safety_out;
   end
endmodule
`default_nettype wire

/* File: sim/safety_gate_monitor_tb.sv */
// Self-checking bench for the safety gate monitor
`default_nettype none
module safety_gate_monitor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset_n = 0, clk_en = 1, supply_ok = 1, manual_mode = 0, weld = 0;
   logic gate_switch_a = 1, gate_switch_b = 1, start_circuit_input = 1;
   logic feedback_loop_input = 1;
   logic earth_fault_sense = 0, short_sense = 0;
   logic [5:0] safe_readback, safety_out;
   logic [3:0] aux_out;
   logic power_indicator, input_a_indicator, input_b_indicator, output_a_indicator;
   logic output_b_indicator, ready, active, earth_fault, wiring_fault, weld_fault;
   int fail_count = 0, n_checks = 0, cycles = 0;
   sgm_safety_gate_monitor #(.SIMUL_CYCLES(8), .EARTH_OFF_CYCLES(20), .CHECK_CYCLES(8))
      sgm_safety_gate_monitor_i (.*);
   sgm_contact_model sgm_contact_model_i (.*);
   always #2.5 clk = ~clk;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic gates(input logic a, input logic b, input int n);
      gate_switch_a = a;
      gate_switch_b = b;
      cyc(n);
   endtask
   task automatic outs(input logic on);
      check({safety_out, output_a_indicator, output_b_indicator}, on ? 8'hff : 8'h00);
      check({aux_out, 3'h0, active}, on ? 8'h01 : 8'hf0);
   endtask
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic t_restart_lock();
      cyc(12);
      outs(0);
      check({6'h00, input_a_indicator, input_b_indicator}, 8'h03);
      check({6'h00, ready, power_indicator}, 8'h03);
      gates(0, 0, 10);
      check({6'h00, input_a_indicator, input_b_indicator}, 8'h00);
      gates(1, 1, 12);
      outs(1);
      gates(0, 1, 10);
      outs(0);
      check({6'h00, input_a_indicator, input_b_indicator}, 8'h01);
      gates(0, 0, 10);
      $display("Test restart_lock done");
   endtask
   task automatic t_manual();
      manual_mode = 1;
      start_circuit_input = 0;
      gates(1, 1, 12);
      outs(0);
      check({7'h00, ready}, 8'h00);
      start_circuit_input = 1;
      cyc(12);
      outs(1);
      gates(0, 0, 10);
      gates(1, 1, 12);
      outs(1);
      gates(0, 0, 10);
      manual_mode = 0;
      $display("Test manual done");
   endtask
   task automatic t_window();
      gates(1, 0, 20);
      gates(1, 1, 12);
      outs(0);
      gates(0, 0, 10);
      gates(0, 1, 4);
      gates(1, 1, 12);
      outs(1);
      $display("Test window done");
   endtask
   task automatic t_wiring();
      short_sense = 1;
      cyc(8);
      check({7'h00, wiring_fault}, 8'h01);
      outs(0);
      short_sense = 0;
      cyc(8);
      outs(0);
      gates(0, 0, 10);
      check({7'h00, wiring_fault}, 8'h00);
      $display("Test wiring done");
   endtask
   task automatic t_earth();
      gates(1, 1, 12);
      earth_fault_sense = 1;
      cyc(8);
      check({6'h00, earth_fault, power_indicator}, 8'h02);
      outs(0);
      earth_fault_sense = 0;
      gates(0, 0, 4);
      supply_ok = 0;
      cyc(10);
      check({6'h00, earth_fault, power_indicator}, 8'h02);
      cyc(20);
      supply_ok = 1;
      cyc(8);
      check({6'h00, earth_fault, power_indicator}, 8'h01);
      gates(1, 1, 12);
      outs(1);
      $display("Test earth done");
   endtask
   task automatic t_weld();
      weld = 1;
      gates(0, 0, 20);
      check({7'h00, weld_fault}, 8'h01);
      gates(1, 1, 12);
      outs(0);
      $display("Test weld done");
   endtask
   task automatic t_freeze();
      clk_en = 0;
      gates(0, 0, 10);
      check({6'h00, input_a_indicator, input_b_indicator}, 8'h03);
      outs(0);
      clk_en = 1;
      cyc(10);
      check({6'h00, input_a_indicator, input_b_indicator}, 8'h00);
      $display("Test freeze done");
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      cyc(5);
      reset_n = 1;
      t_restart_lock();
      t_manual();
      t_window();
      t_wiring();
      t_earth();
      t_weld();
      t_freeze();
      final_report();
   end
endmodule
`default_nettype wire
